// File: src/bpsc_pkg.sv
package bpsc_pkg;
    // line data interface modes
    localparam logic [1:0] MODE_SERIAL = 2'h0;
    localparam logic [1:0] MODE_NIBBLE = 2'h1;
    localparam logic [1:0] MODE_BYTE   = 2'h2;
    localparam logic [3:0] W_SERIAL    = 4'h1;
    localparam logic [3:0] W_NIBBLE    = 4'h4;
    localparam logic [3:0] W_BYTE      = 4'h8;
    localparam int         LINE_W      = 8;
    // clean receive clocks after loading n bits, per mode
    localparam logic [7:0] ACQ_SERIAL  = 8'h32;
    localparam logic [7:0] ACQ_NIBBLE  = 8'h0E;
    localparam logic [7:0] ACQ_BYTE    = 8'h08;
    // loss of sync: errors within a window of bits
    localparam logic [7:0] LOS_ERRS    = 8'h06;
    localparam logic [7:0] LOS_WINDOW  = 8'h40;
    localparam int         CNT_W       = 48;
    localparam int         LFSR_W      = 32;
    localparam int         INJ_W       = 16;
    localparam int         BUF_DEPTH   = 2;
    // values after reset
    localparam logic [LFSR_W-1:0] LFSR_RST  = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  COUNT_RST = 48'h0000_0000_0000;
    localparam logic [7:0]        LINE_RST  = 8'h00;
    localparam logic [7:0]        CNT8_RST  = 8'h00;
    localparam logic [INJ_W-1:0]  INJ_RST   = 16'h0000;
    typedef enum logic [1:0] {
        BPSC_HUNT = 2'b01,
        BPSC_SYNC = 2'b10
    } bpsc_state_e;
endpackage

// File: src/bpsc_sat_acc.sv
`timescale 1ns/100ps
module bpsc_sat_acc
    import bpsc_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // control
    input  wire logic         step,
    input  wire logic         restart,
    input  wire logic [3:0]   add,
    // value
    output logic      [W-1:0] acc
);
    localparam logic [W-1:0] MAXV = '1;
    logic [W:0] sum;
    logic [W-1:0] inc;

    assign inc = step ? {{(W-4){1'b0}}, add} : '0;
    assign sum = {1'b0, acc} + {1'b0, inc};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc <= '0;
        end else if (restart) begin
            acc <= inc;
        end else if (sum[W]) begin
            acc <= MAXV; // stop at full scale
        end else begin
            acc <= sum[W-1:0];
        end
    end
endmodule

// File: src/bpsc_top.sv
`timescale 1ns/100ps
module bpsc_top
    import bpsc_pkg::*;
#(
    parameter int DATA_W = LINE_W,
    parameter int DEPTH  = BUF_DEPTH
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // line side
    input  wire logic              tx_line_clock,
    input  wire logic              tx_clock_gate_in,
    output logic                   gapped_tx_clock_out,
    output logic      [DATA_W-1:0] tx_data_lines,
    input  wire logic              rx_line_clock,
    input  wire logic              rx_clock_gate_in,
    input  wire logic [DATA_W-1:0] rx_data_lines,
    // configuration
    input  wire logic [1:0]        line_mode,
    input  wire logic              repetitive_mode,
    input  wire logic [5:0]        poly_exponent,
    input  wire logic [31:0]       poly_taps,
    input  wire logic [31:0]       rep_pattern,
    input  wire logic [5:0]        rep_length,
    input  wire logic [INJ_W-1:0]  err_interval,
    // control and status
    input  wire logic              latch_counts_bit,
    input  wire logic              sync_lost_clear,
    output logic                   rx_pattern_sync_lost_flag,
    output logic                   rx_in_sync,
    output logic      [CNT_W-1:0]  bit_count,
    output logic      [CNT_W-1:0]  err_count,
    // transmit words
    input  wire logic [DATA_W-1:0] tx_word_data,
    input  wire logic              tx_word_valid,
    output logic                   tx_word_ready
);
    // two-flop synchronizers, third stage for edges
    logic [2:0] tx_line_clock_sq, rclk_sq;
    logic [1:0] ten_sq, ren_sq;
    logic [DATA_W-1:0] rdat_s1_q, rdat_s2_q;
    logic tx_edge_en, rx_edge_en;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_line_clock_sq   <= 3'h0;
            rclk_sq   <= 3'h0;
            ten_sq    <= 2'h0;
            ren_sq    <= 2'h0;
            rdat_s1_q <= '0;
            rdat_s2_q <= '0;
        end else begin
            tx_line_clock_sq   <= {tx_line_clock_sq[1:0], tx_line_clock};
            rclk_sq   <= {rclk_sq[1:0], rx_line_clock};
            ten_sq    <= {ten_sq[0], tx_clock_gate_in};
            ren_sq    <= {ren_sq[0], rx_clock_gate_in};
            rdat_s1_q <= rx_data_lines;
            rdat_s2_q <= rdat_s1_q;
        end
    end

    // advance only on enabled rising edges
    assign tx_edge_en = tx_line_clock_sq[1] && !tx_line_clock_sq[2] && ten_sq[1];
    assign rx_edge_en = rclk_sq[1] && !rclk_sq[2] && ren_sq[1];

    logic [3:0] width;
    logic [DATA_W-1:0] lane_mask;
    always_comb begin
        unique case (line_mode)
            MODE_NIBBLE: width = W_NIBBLE;
            MODE_BYTE:   width = W_BYTE;
            default:     width = W_SERIAL;
        endcase
        lane_mask = DATA_W'((1 << width) - 1); // line 0 is serial/LSB
    end

    // two-entry transmit word buffer
    logic [DATA_W-1:0] buf_mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] wr_ptr_q, rd_ptr_q;
    logic [$clog2(DEPTH):0] fill_q, fill_d;
    logic push, pop;

    assign push = tx_word_valid && tx_word_ready;
    assign pop  = tx_edge_en && (fill_q != '0);
    assign fill_d = fill_q + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_q      <= '0;
            rd_ptr_q      <= '0;
            fill_q        <= '0;
            tx_word_ready <= 1'b0;
        end else begin
            if (push) begin
                buf_mem[wr_ptr_q] <= tx_word_data;
                wr_ptr_q <= (wr_ptr_q == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            fill_q        <= fill_d;
            tx_word_ready <= fill_d < ($clog2(DEPTH) + 1)'(DEPTH);
        end
    end

    // error injection and transmit lines
    logic [INJ_W-1:0] inj_cnt_q;
    logic inject;
    assign inject = (err_interval != INJ_RST) && (inj_cnt_q == err_interval);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            inj_cnt_q <= INJ_RST;
        end else if (tx_edge_en) begin
            inj_cnt_q <= inject ? INJ_RST : inj_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_data_lines <= LINE_RST;
        end else if (pop) begin
            // lines always driven; held between enabled edges
            tx_data_lines <= (buf_mem[rd_ptr_q] ^ {{(DATA_W-1){1'b0}}, inject})
                             & lane_mask;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gapped_tx_clock_out <= 1'b0;
        end else begin
            gapped_tx_clock_out <= tx_line_clock_sq[1] && ten_sq[1];
        end
    end

    // receive pattern synchronizer
    bpsc_state_e state_q;
    logic [LFSR_W-1:0] lfsr_q, lfsr_d;
    logic [4:0] ptr_q, ptr_d;
    logic [7:0] load_q, clean_q, win_bits_q, win_errs_q;
    logic [3:0] errs;
    logic any_mism, synced, acq_done, lose;
    logic [7:0] acq_thr;

    assign synced = (state_q == BPSC_SYNC);

    always_comb begin
        logic bit_v;
        logic exp_v;
        bit_v    = 1'b0;
        exp_v    = 1'b0;
        lfsr_d   = lfsr_q;
        ptr_d    = ptr_q;
        errs     = 4'h0;
        any_mism = 1'b0;
        for (int i = 0; i < DATA_W; i++) begin
            if (4'(i) < width) begin
                bit_v = rdat_s2_q[i];
                if (repetitive_mode) begin
                    exp_v = rep_pattern[ptr_d];
                    // a hunting mismatch holds the pointer, slipping alignment
                    if (synced || (bit_v == exp_v)) begin
                        ptr_d = ({1'b0, ptr_d} == rep_length - 6'h1) ? 5'h0 : ptr_d + 5'h1;
                    end
                end else begin
                    exp_v  = ^(lfsr_d & poly_taps);
                    // hunting self-loads from line, synced runs free
                    lfsr_d = {lfsr_d[LFSR_W-2:0], synced ? exp_v : bit_v};
                end
                if (bit_v != exp_v) begin
                    errs     = errs + 4'h1;
                    any_mism = 1'b1;
                end
            end
        end
    end

    always_comb begin
        unique case (line_mode)
            MODE_NIBBLE: acq_thr = ACQ_NIBBLE;
            MODE_BYTE:   acq_thr = ACQ_BYTE;
            default:     acq_thr = ACQ_SERIAL;
        endcase
        if (repetitive_mode) begin
            acq_done = !any_mism && ((clean_q + {4'h0, width}) >= {2'h0, rep_length});
        end else begin
            acq_done = !any_mism && (load_q >= {2'h0, poly_exponent})
                       && ((clean_q + 8'h01) >= acq_thr);
        end
        lose = synced && ((win_errs_q + {4'h0, errs}) >= LOS_ERRS);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q    <= BPSC_HUNT;
            lfsr_q     <= LFSR_RST;
            ptr_q      <= 5'h0;
            load_q     <= CNT8_RST;
            clean_q    <= CNT8_RST;
            win_bits_q <= CNT8_RST;
            win_errs_q <= CNT8_RST;
        end else if (rx_edge_en) begin
            lfsr_q <= lfsr_d;
            ptr_q  <= ptr_d;
            unique case (state_q)
                BPSC_HUNT: begin
                    if (load_q < {2'h0, poly_exponent}) begin
                        load_q <= load_q + {4'h0, width};
                    end
                    if (any_mism) begin
                        clean_q <= CNT8_RST;
                    end else if (load_q >= {2'h0, poly_exponent} || repetitive_mode) begin
                        clean_q <= clean_q + (repetitive_mode ? {4'h0, width} : 8'h01);
                    end
                    if (acq_done) begin
                        state_q    <= BPSC_SYNC;
                        win_bits_q <= CNT8_RST;
                        win_errs_q <= CNT8_RST;
                    end
                end
                BPSC_SYNC: begin
                    if (lose) begin
                        state_q <= BPSC_HUNT;
                        load_q  <= CNT8_RST;
                        clean_q <= CNT8_RST;
                    end else if ((win_bits_q + {4'h0, width}) >= LOS_WINDOW) begin
                        win_bits_q <= CNT8_RST;
                        win_errs_q <= CNT8_RST;
                    end else begin
                        win_bits_q <= win_bits_q + {4'h0, width};
                        win_errs_q <= win_errs_q + {4'h0, errs};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_pattern_sync_lost_flag <= 1'b0;
            rx_in_sync                <= 1'b0;
        end else begin
            // a new loss wins over a clear in the same cycle
            if (rx_edge_en && lose) begin
                rx_pattern_sync_lost_flag <= 1'b1;
            end else if (sync_lost_clear) begin
                rx_pattern_sync_lost_flag <= 1'b0;
            end
            rx_in_sync <= synced;
        end
    end

    // counters and latch
    logic lc_prev_q, latch_pend_q, latch_do;
    logic [CNT_W-1:0] bit_acc, err_acc;

    assign latch_do = latch_pend_q && rx_edge_en;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lc_prev_q    <= 1'b0;
            latch_pend_q <= 1'b0;
        end else begin
            lc_prev_q <= latch_counts_bit;
            if (latch_counts_bit && !lc_prev_q) begin
                latch_pend_q <= 1'b1;
            end else if (latch_do) begin
                latch_pend_q <= 1'b0;
            end
        end
    end

    bpsc_sat_acc #(.W(CNT_W)) u_bit_acc (
        .ref_clk (ref_clk),
        .rst     (rst),
        .step    (rx_edge_en),  // one per enabled clock
        .restart (latch_do),
        .add     (4'h1),
        .acc     (bit_acc)
    );

    bpsc_sat_acc #(.W(CNT_W)) u_err_acc (
        .ref_clk (ref_clk),
        .rst     (rst),
        .step    (rx_edge_en && synced),
        .restart (latch_do),
        .add     (errs),
        .acc     (err_acc)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_count <= COUNT_RST;
            err_count <= COUNT_RST;
        end else if (latch_do) begin
            bit_count <= bit_acc;
            err_count <= err_acc;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    tx_hold_a: assert property (!tx_edge_en |=> $stable(tx_data_lines))
        else $error("tx lines changed without enabled edge");
    gclk_idle_a: assert property (!ten_sq[1] [*2] |=> !gapped_tx_clock_out)
        else $error("gapped clock active while gate low");
    bit_step_a: assert property (rx_edge_en && !latch_do && !(&bit_acc)
        |=> bit_acc == $past(bit_acc) + 48'h1)
        else $error("bit count did not step once");
    err_gate_a: assert property (!synced && !latch_do |=> $stable(err_acc))
        else $error("error count moved out of sync");
    sat_hold_a: assert property ((&bit_acc) && !latch_do |=> (&bit_acc))
        else $error("bit count wrapped");
    latch_copy_a: assert property (latch_do |=> bit_count == $past(bit_acc)
        && err_count == $past(err_acc) && bit_acc == 48'h1)
        else $error("latch did not copy and restart");
    rx_gate_a: assert property (!rx_edge_en |=> $stable(lfsr_q) && $stable(state_q))
        else $error("receiver advanced without enabled edge");
    los_flag_a: assert property (rx_edge_en && lose
        |=> rx_pattern_sync_lost_flag && state_q == BPSC_HUNT)
        else $error("loss of sync not flagged");
    sync_clean_a: assert property (rx_edge_en && !synced && any_mism
        |=> state_q == BPSC_HUNT)
        else $error("sync declared on errored data");

    sync_got_c: cover property (rx_edge_en && !synced ##1 synced);
    sync_lost_c: cover property (rx_edge_en && lose);
    latch_c: cover property (latch_do ##[1:1000] latch_do);
    buf_full_c: cover property (!tx_word_ready && tx_word_valid);
endmodule

// File: bench/bpsc_line_model.sv
`timescale 1ns/100ps
module bpsc_line_model
    import bpsc_pkg::*;
(
    // phase reference
    input  wire logic        ref_clk,
    // pattern setup
    input  wire logic [1:0]  line_mode,
    input  wire logic        repetitive_mode,
    input  wire logic [31:0] poly_taps,
    input  wire logic [31:0] rep_pattern,
    input  wire logic [5:0]  rep_length,
    // line side
    output logic             rx_line_clock,
    output logic             rx_clock_gate_in,
    output logic [7:0]       rx_data_lines,
    output logic             tx_line_clock,
    output logic             tx_clock_gate_in
);
    logic [31:0] lfsr;
    logic [5:0]  ptr;
    initial begin
        rx_line_clock = 1'b0;
        rx_clock_gate_in = 1'b0;
        rx_data_lines = 8'h00;
        tx_line_clock = 1'b0;
        tx_clock_gate_in = 1'b0;
    end
    task automatic restart();
        lfsr = 32'h0000_0001;
        ptr = 6'h00;
    endtask
    // line clocks stand still outside bursts; gate low keeps a continuous clock
    task automatic rx_burst(input int n, input logic en, input int errs);
        logic [7:0] d;
        logic       b;
        int         w;
        @(posedge ref_clk);
        #1.3;
        w = (line_mode == MODE_BYTE) ? 8 : (line_mode == MODE_NIBBLE) ? 4 : 1;
        for (int k = 0; k < n; k++) begin
            d = ~rx_data_lines;
            // a gated slot carries no pattern bits, so the sequence waits
            for (int i = 0; i < w && en; i++) begin
                if (repetitive_mode) begin
                    b = rep_pattern[ptr];
                    ptr = (ptr + 6'h01 == rep_length) ? 6'h00 : ptr + 6'h01;
                end else begin
                    b = ^(lfsr & poly_taps);
                    lfsr = {lfsr[30:0], b};
                end
                d[i] = b ^ (i == 0 && k >= n - errs);
            end
            // data settles half a period before the rising edge
            rx_data_lines = d;
            rx_clock_gate_in = en;
            #62.5 rx_line_clock = 1'b1;
            #62.5 rx_line_clock = 1'b0;
        end
        rx_clock_gate_in = 1'b0;
        rx_data_lines = ~rx_data_lines;
    endtask
    task automatic tx_burst(input int n, input logic en);
        @(posedge ref_clk);
        #1.3;
        for (int k = 0; k < n; k++) begin
            tx_clock_gate_in = en;
            #62.5 tx_line_clock = 1'b1;
            #62.5 tx_line_clock = 1'b0;
        end
        tx_clock_gate_in = 1'b0;
    endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import bpsc_pkg::*;
    logic              ref_clk, rst, latch_counts_bit, sync_lost_clear;
    logic              repetitive_mode, tx_word_valid, tx_word_ready, gap_q;
    logic              tx_line_clock, tx_clock_gate_in, gapped_tx_clock_out;
    logic              rx_line_clock, rx_clock_gate_in, rx_pattern_sync_lost_flag;
    logic              rx_in_sync;
    logic [1:0]        line_mode;
    logic [7:0]        tx_data_lines, rx_data_lines, tx_word_data;
    logic [INJ_W-1:0]  err_interval;
    logic [31:0]       poly_taps, rep_pattern;
    logic [5:0]        rep_length;
    logic [CNT_W-1:0]  bit_count, err_count;
    int                error_cnt = 0;
    int                checks_done = 0;
    int                gap_rises = 0;
    bpsc_top i_bpsc_top (.ref_clk, .rst, .tx_line_clock, .tx_clock_gate_in,
        .gapped_tx_clock_out, .tx_data_lines, .rx_line_clock, .rx_clock_gate_in,
        .rx_data_lines, .line_mode, .repetitive_mode, .poly_exponent(6'h07),
        .poly_taps, .rep_pattern, .rep_length,
        .err_interval, .latch_counts_bit, .sync_lost_clear, .rx_pattern_sync_lost_flag,
        .rx_in_sync, .bit_count, .err_count, .tx_word_data, .tx_word_valid, .tx_word_ready);
    bpsc_line_model i_bpsc_line_model (.ref_clk, .line_mode, .repetitive_mode,
        .poly_taps, .rep_pattern, .rep_length,
        .rx_line_clock, .rx_clock_gate_in, .rx_data_lines, .tx_line_clock, .tx_clock_gate_in);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        gap_q <= gapped_tx_clock_out;
        if (gapped_tx_clock_out && !gap_q) gap_rises <= gap_rises + 1;
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d of %0d checks", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic restart(input logic [1:0] m, input logic r);
        @(posedge ref_clk);
        line_mode <= m;
        repetitive_mode <= r;
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        i_bpsc_line_model.restart();
    endtask
    task automatic rx(input int n, input logic en, input int errs);
        i_bpsc_line_model.rx_burst(n, en, errs);
        repeat (2) @(posedge ref_clk);
    endtask
    // the latch only takes effect at the next enabled receive edge
    task automatic latch();
        @(posedge ref_clk);
        latch_counts_bit <= 1'b1;
        repeat (3) @(posedge ref_clk);
        latch_counts_bit <= 1'b0;
    endtask
    task automatic push(input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        tx_word_valid <= 1'b1;
        tx_word_data <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (tx_word_ready !== 1'b1 && n < 50);
        tx_word_valid <= 1'b0;
        chk(n < 50, 1'b1);
    endtask
    task automatic tx_step(input int n, input logic en, input logic [7:0] exp);
        int g;
        g = gap_rises;
        i_bpsc_line_model.tx_burst(n, en);
        repeat (4) @(posedge ref_clk);
        chk(gap_rises - g, en ? n : 0);
        chk(tx_data_lines, exp);
    endtask
    task automatic t_acq();
        logic [7:0] acq [3];
        acq = '{ACQ_SERIAL, ACQ_NIBBLE, ACQ_BYTE};
        for (int m = 0; m < 3; m++) begin
            restart(m[1:0], 1'b0);
            rx(int'(acq[m]) + 7, 1'b1, 0);
            chk(rx_in_sync, 1'b1);
        end
    endtask
    task automatic t_poly_cnt();
        latch();
        rx(30, 1'b1, 2);
        rx(5, 1'b0, 0);
        latch();
        rx(1, 1'b1, 0);
        chk(bit_count, 48'd30);
        chk(err_count, 48'd2);
    endtask
    task automatic t_rep();
        restart(MODE_SERIAL, 1'b1);
        latch();
        rx(11, 1'b1, 0);
        chk(rx_in_sync, 1'b0);
        latch();
        rx(1, 1'b1, 0);
        chk(bit_count, 48'd11);
        chk(err_count, 48'd0);
        rx(24, 1'b1, 0);
        chk(rx_in_sync, 1'b1);
        latch();
        rx(40, 1'b1, 3);
        latch();
        rx(1, 1'b1, 0);
        chk(err_count, 48'd3);
        chk(bit_count, 48'd40);
        rx(12, 1'b1, 12);
        chk(rx_pattern_sync_lost_flag, 1'b1);
        chk(rx_in_sync, 1'b0);
        @(posedge ref_clk) sync_lost_clear <= 1'b1;
        @(posedge ref_clk) sync_lost_clear <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(rx_pattern_sync_lost_flag, 1'b0);
    endtask
    task automatic t_tx();
        restart(MODE_BYTE, 1'b0);
        push(8'h5A);
        push(8'hC3);
        @(posedge ref_clk);
        chk(tx_word_ready, 1'b0);
        tx_step(1, 1'b1, 8'h5A);
        tx_step(3, 1'b0, 8'h5A);
        chk(tx_word_ready, 1'b1);
        tx_step(1, 1'b1, 8'hC3);
        tx_step(1, 1'b1, 8'hC3);
        restart(MODE_NIBBLE, 1'b0);
        push(8'hA5);
        tx_step(1, 1'b1, 8'h05);
    endtask
    task automatic t_inj();
        int ones;
        ones = 0;
        err_interval <= 16'h0001;
        restart(MODE_SERIAL, 1'b0);
        for (int k = 0; k < 4; k++) begin
            push(8'h00);
            i_bpsc_line_model.tx_burst(1, 1'b1);
            repeat (4) @(posedge ref_clk);
            ones += tx_data_lines[0];
        end
        chk(ones, 2);
        chk(tx_data_lines[7:1], 7'h00);
    endtask
    initial begin
        rst = 1'b1;
        latch_counts_bit = 1'b0;
        sync_lost_clear = 1'b0;
        line_mode = MODE_SERIAL;
        repetitive_mode = 1'b0;
        err_interval = 16'h0000;
        poly_taps = 32'h0000_0060;
        rep_pattern = 32'h0000_0B4E;
        rep_length = 6'h0C;
        tx_word_data = 8'h00;
        tx_word_valid = 1'b0;
        // every control input is programmed before use
        t_acq();
        t_poly_cnt();
        t_rep();
        t_tx();
        t_inj();
        close_out();
    end
    initial begin
        #300000;
        error_cnt++;
        $display("MISMATCH at %0t: watchdog got %0h expected %0h", $time, 0, 1);
        close_out();
    end
endmodule
